// ---- pkg/pfc_regs.svh ----
// Behaviour
// - Program counter is 12 bits, addressing 4096 bytes directly.
// - Beyond 4096 bytes, a separate page register extends the counter.
// - Ordinary instructions advance the counter by one.
// - Relative branch adds the signed offset to the counter.
// - Call, interrupt, reset and returns each load the counter from their source.
// - Three carry/zero pairs: normal, maskable interrupt, non-maskable.
// - Interrupt entry selects its pair; interrupt return restores the previous pair.
// - Only the active pair is reachable; switching never clears any pair.
// - Carry follows carry/borrow, bit-test copies, rotate-left shifts through.
// - Zero is set when the last result is zero, else cleared.
// - After reset the non-maskable context and its pair are active.
// - Return stack has six 12-bit levels, no visible pointer; the core shows its level on o_stack_level and in the status word.
// - Call or interrupt shifts levels down, counter into first level.
// - Either return moves first level into counter, shifts the rest up.
// - Beyond six nested pushes the stack stays deepest, oldest address lost.
// - Return on empty stack keeps stack at top, continues with next instruction.
// - Reset vector at top two bytes, non-maskable below, maskable twelve bytes lower.
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

// ============================================================
// Widths and sizes
`define PFC_PC_W 12
`define PFC_STACK_DEPTH 6
`define PFC_PAGE_W 4
`define PFC_DATA_W 8
`define PFC_ADDR_W 12

// ============================================================
// Program memory vectors
`define PFC_VEC_RESET 12'hFFE
`define PFC_VEC_NMI 12'hFFC
`define PFC_VEC_IRQ_BASE 12'hFF0

// ============================================================
// Register offsets and status fields
`define PFC_OFS_PAGE 12'h000
`define PFC_OFS_STATUS 12'h004
`define PFC_ST_PC_LSB 0
`define PFC_ST_LEVEL_LSB 12
`define PFC_ST_CTX_LSB 16
`define PFC_ST_CARRY_BIT 18
`define PFC_ST_ZERO_BIT 19

// ============================================================
// Reset values
`define PFC_PAGE_RST 4'h0
`define PFC_FLAG_RST 1'b0
`define PFC_STACK_RST 12'h000

`endif

// ---- pkg/pfc_pkg.sv ----
package pfc_pkg;

  // ============================================================
  // Next-address command from the decoder
  typedef enum logic [2:0] {
    PFC_CMD_HOLD,
    PFC_CMD_INCR,
    PFC_CMD_BRANCH,
    PFC_CMD_CALL,
    PFC_CMD_IRQ,
    PFC_CMD_NMI,
    PFC_CMD_SUB_RETURN,
    PFC_CMD_INT_RETURN
  } pfc_cmd_t;

  // ============================================================
  // Execution context, also the flag pair index
  typedef enum logic [1:0] {
    PFC_CTX_NORMAL,
    PFC_CTX_IRQ,
    PFC_CTX_NMI
  } pfc_ctx_t;

endpackage

// ---- rtl/pfc_core.sv ----
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "pfc_regs.svh"

module pfc_core #(
  parameter int STACK_DEPTH = `PFC_STACK_DEPTH,
  parameter int PAGE_W = `PFC_PAGE_W,
  parameter int DATA_W = `PFC_DATA_W
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input pfc_pkg::pfc_cmd_t i_cmd,
  input wire logic [`PFC_PC_W-1:0] i_call_target,
  input wire logic [`PFC_PC_W-1:0] i_branch_offset,
  input wire logic [1:0] i_irq_vector_sel,
  input wire logic i_carry_we,
  input wire logic i_carry_value,
  input wire logic i_zero_we,
  input wire logic [DATA_W-1:0] i_alu_result,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`PFC_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [`PFC_PC_W-1:0] o_pc,
  output logic [PAGE_W-1:0] o_page,
  output logic o_carry,
  output logic o_zero,
  output pfc_pkg::pfc_ctx_t o_context,
  output logic [$clog2(STACK_DEPTH+1)-1:0] o_stack_level
);

  localparam int PC_W = `PFC_PC_W;
  localparam int LVL_W = $clog2(STACK_DEPTH+1);
  localparam int CTX_N = 3;

  // ============================================================
  // State
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  pfc_pkg::pfc_ctx_t ctx_reg;
  pfc_pkg::pfc_ctx_t ctx_next;
  logic [LVL_W-1:0] level_reg;
  logic [PC_W-1:0] stack_reg [STACK_DEPTH];
  pfc_pkg::pfc_ctx_t ctx_stack_reg [STACK_DEPTH];
  logic carry_reg [CTX_N];
  logic zero_reg [CTX_N];
  logic [PAGE_W-1:0] page_reg;
  logic [31:0] prdata_reg;
  logic [31:0] status_word;
  logic do_push;
  logic do_pop;
  logic stack_empty;
  logic [PC_W-1:0] pc_plus_one;
  logic [PC_W-1:0] irq_vector;

  // ============================================================
  // Stack command decode
  assign stack_empty = (level_reg == '0);
  assign do_push = (i_cmd == pfc_pkg::PFC_CMD_CALL) || (i_cmd == pfc_pkg::PFC_CMD_IRQ) ||
                   (i_cmd == pfc_pkg::PFC_CMD_NMI);
  assign do_pop = ((i_cmd == pfc_pkg::PFC_CMD_SUB_RETURN) ||
                   (i_cmd == pfc_pkg::PFC_CMD_INT_RETURN)) && !stack_empty;
  assign pc_plus_one = PC_W'(pc_reg + 1'b1);
  assign irq_vector = PC_W'(`PFC_VEC_IRQ_BASE + {9'h000, i_irq_vector_sel, 1'b0});

  // ============================================================
  // Next program counter
  always_comb begin
    case (i_cmd)
      pfc_pkg::PFC_CMD_INCR: pc_next = pc_plus_one;
      pfc_pkg::PFC_CMD_BRANCH: pc_next = PC_W'(pc_reg + i_branch_offset);
      pfc_pkg::PFC_CMD_CALL: pc_next = i_call_target;
      pfc_pkg::PFC_CMD_IRQ: pc_next = irq_vector;
      pfc_pkg::PFC_CMD_NMI: pc_next = `PFC_VEC_NMI;
      pfc_pkg::PFC_CMD_SUB_RETURN,
      pfc_pkg::PFC_CMD_INT_RETURN: pc_next = stack_empty ? pc_plus_one : stack_reg[0];
      default: pc_next = pc_reg;
    endcase
  end

  // Program counter, reset vector on reset
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pc_reg <= `PFC_VEC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ============================================================
  // Context selection
  always_comb begin
    case (i_cmd)
      pfc_pkg::PFC_CMD_IRQ: ctx_next = pfc_pkg::PFC_CTX_IRQ;
      pfc_pkg::PFC_CMD_NMI: ctx_next = pfc_pkg::PFC_CTX_NMI;
      pfc_pkg::PFC_CMD_INT_RETURN: ctx_next = stack_empty ? pfc_pkg::PFC_CTX_NORMAL :
                                              ctx_stack_reg[0];
      default: ctx_next = ctx_reg;
    endcase
  end

  // Context register, non-maskable after reset
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctx_reg <= pfc_pkg::PFC_CTX_NMI;
    end else begin
      ctx_reg <= ctx_next;
    end
  end

  // ============================================================
  // Flag pairs, one per context, written only when active
  for (genvar c = 0; c < CTX_N; c++) begin : g_flags
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        carry_reg[c] <= `PFC_FLAG_RST;
        zero_reg[c] <= `PFC_FLAG_RST;
      end else if (ctx_reg == pfc_pkg::pfc_ctx_t'(c)) begin
        if (i_carry_we) begin
          carry_reg[c] <= i_carry_value;
        end
        if (i_zero_we) begin
          zero_reg[c] <= (i_alu_result == '0);
        end
      end
    end
  end

  // Active pair seen by the decoder
  assign o_carry = carry_reg[ctx_reg];
  assign o_zero = zero_reg[ctx_reg];

  // ============================================================
  // Return stack levels, shifting down on push, up on pop
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_level
    logic [PC_W-1:0] above;
    logic [PC_W-1:0] below;
    pfc_pkg::pfc_ctx_t above_ctx;
    pfc_pkg::pfc_ctx_t below_ctx;
    if (i == 0) begin : g_first
      assign above = pc_reg;
      assign above_ctx = ctx_reg;
    end else begin : g_inner
      assign above = stack_reg[i-1];
      assign above_ctx = ctx_stack_reg[i-1];
    end
    if (i == STACK_DEPTH-1) begin : g_last
      assign below = stack_reg[i];
      assign below_ctx = ctx_stack_reg[i];
    end else begin : g_upper
      assign below = stack_reg[i+1];
      assign below_ctx = ctx_stack_reg[i+1];
    end
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        stack_reg[i] <= `PFC_STACK_RST;
        ctx_stack_reg[i] <= pfc_pkg::PFC_CTX_NORMAL;
      end else if (do_push) begin
        stack_reg[i] <= above;
        ctx_stack_reg[i] <= above_ctx;
      end else if (do_pop) begin
        stack_reg[i] <= below;
        ctx_stack_reg[i] <= below_ctx;
      end
    end
  end

  // Occupancy, saturating at both ends
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_reg <= '0;
    end else if (do_push && (level_reg != LVL_W'(STACK_DEPTH))) begin
      level_reg <= LVL_W'(level_reg + 1'b1);
    end else if (do_pop) begin
      level_reg <= LVL_W'(level_reg - 1'b1);
    end
  end

  // ============================================================
  // APB slave: page control and status readback
  always_comb begin
    status_word = '0;
    status_word[`PFC_ST_PC_LSB +: PC_W] = pc_reg;
    status_word[`PFC_ST_LEVEL_LSB +: LVL_W] = level_reg;
    status_word[`PFC_ST_CTX_LSB +: 2] = ctx_reg;
    status_word[`PFC_ST_CARRY_BIT] = carry_reg[ctx_reg];
    status_word[`PFC_ST_ZERO_BIT] = zero_reg[ctx_reg];
  end

  // Page register extends the counter beyond 4096 bytes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      page_reg <= `PFC_PAGE_RST;
    end else if (i_psel && i_penable && i_pwrite && (i_paddr == `PFC_OFS_PAGE)) begin
      page_reg <= i_pwdata[PAGE_W-1:0];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_reg <= '0;
    end else if (i_psel && !i_penable) begin
      if (i_paddr == `PFC_OFS_PAGE) begin
        prdata_reg <= 32'(page_reg);
      end else if (i_paddr == `PFC_OFS_STATUS) begin
        prdata_reg <= status_word;
      end else begin
        prdata_reg <= '0;
      end
    end
  end

  // Zero-wait answer, error on unmapped address
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && (i_paddr != `PFC_OFS_PAGE) &&
                     (i_paddr != `PFC_OFS_STATUS);
  assign o_prdata = prdata_reg;
  assign o_pc = pc_reg;
  assign o_page = page_reg;
  assign o_context = ctx_reg;
  assign o_stack_level = level_reg;

  // ============================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  a_pc_incr_step: assert property (
    i_cmd == pfc_pkg::PFC_CMD_INCR |=> pc_reg == PC_W'($past(pc_reg) + 12'h001))
    else $error("counter did not advance by one");

  a_branch_sum_load: assert property (
    i_cmd == pfc_pkg::PFC_CMD_BRANCH |=>
      pc_reg == PC_W'($past(pc_reg) + $past(i_branch_offset)))
    else $error("branch target is not counter plus offset");

  a_call_push_load: assert property (
    i_cmd == pfc_pkg::PFC_CMD_CALL |=>
      pc_reg == $past(i_call_target) && stack_reg[0] == $past(pc_reg))
    else $error("call did not load target and push counter");

  a_nmi_entry_vector: assert property (
    i_cmd == pfc_pkg::PFC_CMD_NMI |=>
      pc_reg == `PFC_VEC_NMI && ctx_reg == pfc_pkg::PFC_CTX_NMI)
    else $error("non-maskable entry vector or context wrong");

  a_irq_vector_load: assert property (
    i_cmd == pfc_pkg::PFC_CMD_IRQ |=>
      pc_reg == (`PFC_VEC_IRQ_BASE | {9'h000, $past(i_irq_vector_sel), 1'b0}) &&
      ctx_reg == pfc_pkg::PFC_CTX_IRQ && stack_reg[0] == $past(pc_reg))
    else $error("maskable entry vector, context or push wrong");

  a_return_pop_load: assert property (
    !stack_empty && (i_cmd == pfc_pkg::PFC_CMD_SUB_RETURN || i_cmd == pfc_pkg::PFC_CMD_INT_RETURN)
      |=> pc_reg == $past(stack_reg[0]) && stack_reg[0] == $past(stack_reg[1]) &&
      level_reg == LVL_W'($past(level_reg) - 1'b1))
    else $error("return did not pop the first level");

  a_irq_ctx_return: assert property (
    ctx_reg == pfc_pkg::PFC_CTX_NORMAL && i_cmd == pfc_pkg::PFC_CMD_IRQ ##1
    i_cmd == pfc_pkg::PFC_CMD_INT_RETURN |=> ctx_reg == pfc_pkg::PFC_CTX_NORMAL)
    else $error("interrupt return did not restore context");

  a_flags_kept_switch: assert property (
    i_cmd == pfc_pkg::PFC_CMD_IRQ && ctx_reg == pfc_pkg::PFC_CTX_NORMAL |=>
      carry_reg[0] == ($past(i_carry_we) ? $past(i_carry_value) : $past(carry_reg[0])) &&
      zero_reg[0] == ($past(i_zero_we) ? ($past(i_alu_result) == '0) : $past(zero_reg[0])) &&
      carry_reg[1] == $past(carry_reg[1]) && zero_reg[1] == $past(zero_reg[1]))
    else $error("flag pair changed on context switch");

  a_carry_write: assert property (
    i_carry_we |=> o_carry == $past(i_carry_value) || ctx_reg != $past(ctx_reg))
    else $error("carry flag does not take the written value");

  a_zero_result: assert property (
    i_zero_we |=> o_zero == ($past(i_alu_result) == '0) || ctx_reg != $past(ctx_reg))
    else $error("zero flag does not follow result");

  a_level_saturate: assert property (
    level_reg == LVL_W'(STACK_DEPTH) && do_push |=> level_reg == LVL_W'(STACK_DEPTH))
    else $error("stack level passed the deepest position");

  a_push_level_step: assert property (
    do_push && level_reg != LVL_W'(STACK_DEPTH) |=>
      level_reg == LVL_W'($past(level_reg) + 1'b1))
    else $error("stack level did not count a push");

  a_empty_return: assert property (
    stack_empty && i_cmd == pfc_pkg::PFC_CMD_SUB_RETURN |=>
      stack_empty && pc_reg == PC_W'($past(pc_reg) + 12'h001))
    else $error("empty return did not continue in line");

  c_stack_overflow: cover property (level_reg == LVL_W'(STACK_DEPTH) && do_push);
  c_int_return_restore: cover property (!stack_empty && i_cmd == pfc_pkg::PFC_CMD_INT_RETURN);
  c_empty_return: cover property (stack_empty && i_cmd == pfc_pkg::PFC_CMD_INT_RETURN);
  c_nested_irq: cover property (ctx_reg == pfc_pkg::PFC_CTX_IRQ && i_cmd == pfc_pkg::PFC_CMD_NMI);
  c_branch_taken: cover property (i_cmd == pfc_pkg::PFC_CMD_BRANCH);

endmodule

// ---- tb/pfc_decoder_model.sv ----
`timescale 1ns/1ps
// ============================================================
// Decoder and program memory stand-in driving the command port
module pfc_decoder_model (
  input wire logic i_reset_n,
  input wire logic i_stall,
  input pfc_pkg::pfc_cmd_t i_req_cmd,
  input wire logic [11:0] i_req_target,
  input wire logic [11:0] i_req_offset,
  input wire logic [1:0] i_req_sel,
  output pfc_pkg::pfc_cmd_t o_cmd,
  output logic [11:0] o_call_target,
  output logic [11:0] o_branch_offset,
  output logic [1:0] o_irq_vector_sel
);
  // Nothing issued in reset or while a slow fetch stalls
  assign o_cmd = (!i_reset_n || i_stall) ? pfc_pkg::PFC_CMD_HOLD : i_req_cmd;
  // Operands valid only beside their command, otherwise inverted garbage
  assign o_call_target = (o_cmd == pfc_pkg::PFC_CMD_CALL) ? i_req_target : ~i_req_target;
  assign o_branch_offset = (o_cmd == pfc_pkg::PFC_CMD_BRANCH) ? i_req_offset : ~i_req_offset;
  assign o_irq_vector_sel = (o_cmd == pfc_pkg::PFC_CMD_IRQ) ? i_req_sel : ~i_req_sel;
endmodule

// ---- tb/test_pc_flag_bank_hw_stack.sv ----
`timescale 1ns/1ps
module test_pc_flag_bank_hw_stack;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic stall = 1'b0;
  pfc_pkg::pfc_cmd_t req_cmd = pfc_pkg::PFC_CMD_HOLD;
  pfc_pkg::pfc_cmd_t cmd;
  logic [11:0] req_target = 12'h000, req_offset = 12'h000, call_target, branch_offset;
  logic [1:0] req_sel = 2'h0, sel;
  logic carry_we = 1'b0, carry_value = 1'b0, zero_we = 1'b0;
  logic [7:0] alu_result = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, carry, zero;
  logic [11:0] pc;
  logic [3:0] page;
  pfc_pkg::pfc_ctx_t cur_ctx, m_ctx;
  logic [2:0] level, m_c, m_z;
  logic [11:0] m_pc;
  logic [11:0] m_stk [6];
  pfc_pkg::pfc_ctx_t m_cst [6];
  int m_lvl, miscompares = 0, n_checks = 0;
  logic [31:0] seed = 32'h000177AF;

  // ============================================================
  // Clock, partner and device
  always #5 i_clock = ~i_clock;
  pfc_decoder_model partner (.i_reset_n(i_reset_n), .i_stall(stall), .i_req_cmd(req_cmd),
    .i_req_target(req_target), .i_req_offset(req_offset), .i_req_sel(req_sel), .o_cmd(cmd),
    .o_call_target(call_target), .o_branch_offset(branch_offset), .o_irq_vector_sel(sel));
  pfc_core dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_cmd(cmd),
    .i_call_target(call_target), .i_branch_offset(branch_offset), .i_irq_vector_sel(sel),
    .i_carry_we(carry_we), .i_carry_value(carry_value), .i_zero_we(zero_we),
    .i_alu_result(alu_result), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_pc(pc), .o_page(page), .o_carry(carry), .o_zero(zero),
    .o_context(cur_ctx), .o_stack_level(level));

  // ============================================================
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [31:0] status();
    return {12'h000, m_z[m_ctx], m_c[m_ctx], m_ctx, 1'b0, m_lvl[2:0], m_pc};
  endfunction
  task chk(input logic ok, input string msg);
    n_checks++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task issue(input pfc_pkg::pfc_cmd_t c, input logic [11:0] t);
    @(posedge i_clock);
    req_cmd <= c;
    req_target <= t;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] ex,
           input logic err);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    chk(pslverr === err, "error response");
    if (!w) chk(prdata === ex, "read data");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ============================================================
  // Reference model, sampling the same inputs at the same edge
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m_pc = 12'hFFE;
      m_ctx = pfc_pkg::PFC_CTX_NMI;
      m_lvl = 0;
      m_c = 3'h0;
      m_z = 3'h0;
    end else begin
      if (carry_we) m_c[m_ctx] = carry_value;
      if (zero_we) m_z[m_ctx] = (alu_result == 8'h00);
      if (cmd inside {pfc_pkg::PFC_CMD_CALL, pfc_pkg::PFC_CMD_IRQ, pfc_pkg::PFC_CMD_NMI}) begin
        for (int i = 5; i > 0; i--) begin
          m_stk[i] = m_stk[i-1];
          m_cst[i] = m_cst[i-1];
        end
        m_stk[0] = m_pc;
        m_cst[0] = m_ctx;
        if (m_lvl < 6) m_lvl++;
      end
      case (cmd)
        pfc_pkg::PFC_CMD_INCR: m_pc = m_pc + 12'h001;
        pfc_pkg::PFC_CMD_BRANCH: m_pc = m_pc + branch_offset;
        pfc_pkg::PFC_CMD_CALL: m_pc = call_target;
        pfc_pkg::PFC_CMD_IRQ: begin
          m_pc = 12'hFF0 + {9'h000, sel, 1'b0};
          m_ctx = pfc_pkg::PFC_CTX_IRQ;
        end
        pfc_pkg::PFC_CMD_NMI: begin
          m_pc = 12'hFFC;
          m_ctx = pfc_pkg::PFC_CTX_NMI;
        end
        pfc_pkg::PFC_CMD_SUB_RETURN, pfc_pkg::PFC_CMD_INT_RETURN: begin
          if (m_lvl == 0) begin
            m_pc = m_pc + 12'h001;
            if (cmd == pfc_pkg::PFC_CMD_INT_RETURN) m_ctx = pfc_pkg::PFC_CTX_NORMAL;
          end else begin
            m_pc = m_stk[0];
            if (cmd == pfc_pkg::PFC_CMD_INT_RETURN) m_ctx = m_cst[0];
            for (int i = 0; i < 5; i++) begin
              m_stk[i] = m_stk[i+1];
              m_cst[i] = m_cst[i+1];
            end
            m_lvl--;
          end
        end
        default: ;
      endcase
    end
  end

  // Compare every settled cycle
  always @(negedge i_clock) begin
    if (i_reset_n) begin
      chk(pc === m_pc, "program counter");
      chk(cur_ctx === m_ctx, "context");
      chk(level === m_lvl[2:0], "stack level");
      chk(carry === m_c[m_ctx], "carry");
      chk(zero === m_z[m_ctx], "zero");
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(negedge i_clock);
    chk(pc === 12'hFFE && cur_ctx === pfc_pkg::PFC_CTX_NMI, "reset state");
    issue(pfc_pkg::PFC_CMD_INT_RETURN, 12'h000);
    for (int i = 0; i < 8; i++) issue(pfc_pkg::PFC_CMD_CALL, 12'h100 + i[11:0]);
    for (int i = 0; i < 8; i++) issue(pfc_pkg::PFC_CMD_SUB_RETURN, 12'h000);
    $display("stack overflow and underflow test done");
    for (int i = 0; i < 2000; i++) begin
      r = rnd();
      @(posedge i_clock);
      req_cmd <= pfc_pkg::pfc_cmd_t'(r[2:0]);
      req_target <= r[14:3];
      req_offset <= r[26:15];
      req_sel <= r[28:27];
      stall <= (r[31:30] == 2'h3);
      r = rnd();
      carry_we <= r[0];
      carry_value <= r[1];
      zero_we <= r[2];
      alu_result <= r[3] ? 8'h00 : r[11:4];
    end
    $display("random command test done");
    @(posedge i_clock);
    stall <= 1'b1;
    carry_we <= 1'b0;
    zero_we <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000000A, 32'h0, 1'b0);
    apb(1'b0, 12'h000, 32'h0, 32'h0000000A, 1'b0);
    apb(1'b1, 12'h004, 32'hFFFFFFFF, 32'h0, 1'b0);
    apb(1'b0, 12'h004, 32'h0, status(), 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
    chk(page === 4'hA, "page output");
    $display("register test done");
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk(pc === 12'hFFE && level === 3'h0 && page === 4'h0, "mid-run reset");
    i_reset_n <= 1'b1;
    stall <= 1'b0;
    req_cmd <= pfc_pkg::PFC_CMD_IRQ;
    repeat (4) @(posedge i_clock);
    $display("reset test done");
    print_verdict();
  end

  // Watchdog on a hung run
  initial begin
    #300000;
    miscompares++;
    print_verdict();
  end
endmodule
